// ==== bench/qdfsl_host_model.sv ====
/*
  Host model: serial link master for the quad driver fault link.
  Assumes the device samples all pins on clk_sys; inputs change 1 ns after an edge.
*/
`timescale 1ns/1ps
module qdfsl_host_model (
  // Clock
  input  wire logic clk_sys,
  // Device serial output
  input  wire logic so_out,
  input  wire logic so_oe,
  // Host driven lines
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  logic so_last;
  logic so_line;

  initial begin
    cs_n    = 1'b1;
    sck     = 1'b0;
    si      = 1'b0;
    so_last = 1'b0;
  end

  // Released line shows inverse of last value, so stale data cannot pass
  always @(posedge clk_sys) begin
    if (so_oe) begin
      so_last <= so_out;
    end
  end
  assign so_line = so_oe ? so_out : ~so_last;

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  // one continuous select; byte k sent is base+k, MSB first
  task automatic xfer(input int n, input int half, input logic [7:0] base,
                      output logic [15:0] rx, output logic first);
    logic [7:0] tx;
    tick(1);
    // clock already low when select falls
    cs_n = 1'b0;
    tick(half);
    first = so_line;
    for (int i = 0; i < n * 8; i++) begin
      tx  = base + 8'(i / 8);
      si  = tx[7 - (i % 8)];
      sck = 1'b1;
      tick(half);
      if (i < 16) begin
        rx[15 - i] = so_line;
      end
      sck = 1'b0;
      tick(half);
    end
    // clock stays low while select returns high
    cs_n = 1'b1;
    tick(2);
  endtask

  // Clock edges without select, commanded by the idle scenario
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      sck = 1'b1;
      tick(2);
      sck = 1'b0;
      tick(2);
    end
  endtask
endmodule

// ==== bench/tb.sv ====
/*
  Self-checking bench for qdfsl_top with the host model on the serial link.
  Assumes a 50 MHz clk_sys and assertions living inside the design files.
*/
`timescale 1ns/1ps
module tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        flag_clear_n = 1'b1;
  logic        supply_ok = 1'b1;
  logic [3:0]  chan_in = 4'h0;
  logic [3:0]  overtemp_detect = 4'h0;
  logic [3:0]  openload_detect = 4'h0;
  logic [3:0]  drive_on;
  logic        int_out, int_oe, cs_n, sck, si, so_out, so_oe;
  logic        rx_valid, rx_ready = 1'b0, rx_overrun;
  logic [7:0]  rx_data;
  logic [15:0] rx;
  logic        first;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #10 clk_sys = ~clk_sys;

  qdfsl_top #(.FIFO_DEPTH(32)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .flag_clear_n(flag_clear_n),
    .supply_ok(supply_ok), .chan_in(chan_in), .drive_on(drive_on), .overtemp_detect(overtemp_detect),
    .openload_detect(openload_detect), .int_out(int_out), .int_oe(int_oe), .cs_n(cs_n), .sck(sck),
    .si(si), .so_out(so_out), .so_oe(so_oe), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .rx_overrun(rx_overrun));

  qdfsl_host_model host (.clk_sys(clk_sys), .so_out(so_out), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, well above the roughly 1600 cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Slow host read of the flags, then the captured byte is drained
  task automatic read_flags(input logic [7:0] exp);
    host.xfer(1, 5, 8'h3c, rx, first);
    chk(16'(rx[15:8]), 16'(exp), "flag byte");
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask

  task automatic t_reset();
    chk(16'({drive_on, so_oe, rx_valid, int_oe, rx_overrun, int_out}), 16'h0, "reset state");
  endtask

  task automatic t_flags();
    int n;
    chan_in = 4'h7;
    tick(2);
    overtemp_detect = 4'h2;
    openload_detect = 4'h8;
    tick(1);
    overtemp_detect = 4'h0;
    openload_detect = 4'h0;
    n = 0;
    while (!int_oe && n < 5) begin
      tick(1);
      n++;
    end
    n = 0;
    while (int_oe === 1'b1 && n < 400) begin
      flag_clear_n    = (n == 10) ? 1'b0 : 1'b1;
      overtemp_detect = (n == 20) ? 4'h1 : 4'h0;
      openload_detect = (n == 20) ? 4'h8 : 4'h0;
      tick(1);
      n++;
    end
    chk(16'(n), 16'd150, "interrupt width");
    tick(5);
    chk(16'({int_oe, drive_on}), 16'h04, "after pulse");
    host.xfer(2, 2, 8'ha5, rx, first);
    chk(16'(first), 16'h0, "level before clock");
    chk(rx, 16'h81a5, "flags then pass-through");
    chk(16'({rx_valid, rx_data}), 16'h1a5, "byte one");
    rx_ready = 1'b1;
    tick(1);
    chk(16'({rx_valid, rx_data}), 16'h1a6, "byte two");
    tick(1);
    rx_ready = 1'b0;
    chk(16'(rx_valid), 16'h0, "fifo empty");
    chan_in = 4'h4;
    tick(2);
    chan_in = 4'h7;
    tick(2);
    chk(16'(drive_on), 16'h7, "latch re-armed");
  endtask

  task automatic t_idle();
    host.idle_clocks(8);
    chk(16'({so_oe, rx_valid}), 16'h0, "idle clocks");
  endtask

  task automatic t_openload();
    chan_in = 4'hf;
    tick(2);
    chan_in = 4'h7;
    tick(2);
    read_flags(8'h01);
  endtask

  task automatic t_clear();
    flag_clear_n = 1'b0;
    tick(2);
    chk(16'(drive_on), 16'h0, "drivers off in clear");
    read_flags(8'h00);
    flag_clear_n = 1'b1;
    chan_in = 4'h0;
    tick(2);
    chan_in = 4'h7;
    tick(2);
    supply_ok = 1'b0;
    tick(2);
    chk(16'(drive_on), 16'h0, "drivers off low supply");
    supply_ok = 1'b1;
    flag_clear_n = 1'b0;
    tick(1);
    flag_clear_n = 1'b1;
    chan_in = 4'h0;
    tick(2);
    chan_in = 4'h7;
    tick(2);
    chk(16'(drive_on), 16'h7, "drivers back");
  endtask

  task automatic t_fifo();
    host.xfer(33, 2, 8'h10, rx, first);
    chk(16'(rx_overrun), 16'h1, "overrun");
    rx_ready = 1'b1;
    for (int k = 0; k < 32; k++) begin
      chk(16'({rx_valid, rx_data}), 16'({1'b1, 8'h10 + 8'(k)}), "drain");
      tick(1);
    end
    rx_ready = 1'b0;
    chk(16'(rx_valid), 16'h0, "drained");
  endtask

  initial begin
    tick(10);
    rst_n = 1'b1;
    tick(1);
    t_reset();
    t_flags();
    t_idle();
    t_openload();
    t_clear();
    t_fifo();
    give_verdict();
  end
endmodule

// ==== core/qdfsl_pkg.sv ====
/*
  Constants, types and bit layout of the quad driver fault serial link.
  Assumes a 50 MHz clk_sys and link pins sampled synchronously to it.
*/
// Summary of operation
// [RULE1] Eight fault flags: overtemp and open-load for channels A to D.
// [RULE2] Bits 0..3 carry overtemp A..D, bits 4..7 open-load A..D.
// [RULE3] With chip select low, output MSB first, changing on rising serial clock.
// [RULE4] Serial input sampled into the shift register on falling serial clock.
// [RULE5] Chip select falling loads current fault flags into the shift register.
// [RULE6] On chip select fall, output leaves high-Z, drives low until first rise.
// [RULE7] Devices daisy-chain: serial output feeds next input, shared chip select.
// [RULE8] Host holds serial clock low when chip select falls.
// [RULE9] Host keeps serial clock low while chip select returns high.
// [RULE10] Host performs one continuous transfer while chip select is low.
// [RULE11] Reset input low clears fault flags, leaves shift register unchanged.
// [RULE12] Reset input low forces all four output drivers off.
// [RULE13] Host clears shift register by chip select fall during/after reset.
// [RULE14] Supply below power-on threshold turns all output drivers off.
// [RULE15] Host applies explicit reset after a power-on-reset event.
// [RULE16] Overtemp turns channel latch off, sets flag; next input rise re-arms.
// [RULE17] Open-load flag set while off, cleared on next input falling edge.
// [RULE18] OR of flags fires one-shot low interrupt; retriggers ignored meanwhile.
// [RULE19] Chip select high: output high-Z, serial clock ignored, register kept.
// [RULE20] Eight-bit register: input appears at output after eight clocks.
package qdfsl_pkg;
  localparam int NUM_CHAN      = 4;
  localparam int DIAG_W        = 8;
  localparam int OT_LSB        = 0;
  localparam int OL_LSB        = 4;
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_INT_MIN_US  = 3;
  localparam int INT_CYCLES    = (T_INT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_CNT_W     = 8;
  localparam int BIT_CNT_W     = 3;
  localparam logic [DIAG_W-1:0]    DIAG_RESET = 8'h00;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST   = 3'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_FIRST  = 3'h0;
  localparam int FIFO_DEPTH    = 32;
  typedef enum logic {QDFSL_IDLE, QDFSL_SELECTED} qdfsl_link_t;
endpackage

// ==== core/qdfsl_top.sv ====
/*
  Quad driver fault flags, gate latches, interrupt one-shot, serial diagnostic
  link and a FIFO of received serial bytes. Assumes all pins are synchronous
  to clk_sys and the serial clock is far slower than clk_sys.
*/
`timescale 1ns/1ps
module qdfsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  logic [AW:0]      next_count;
  logic [AW-1:0]    next_rd;

  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign in_ready   = (count != (AW+1)'(DEPTH));
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign next_rd    = !pop ? rd_ptr : (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;

  // Registered head, a write into the next read slot is forwarded
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
    out_data <= (push && wr_ptr == next_rd) ? in_data : mem[next_rd];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      rd_ptr    <= next_rd;
      count     <= next_count;
      out_valid <= (next_count != '0);
    end
  end
endmodule

module qdfsl_top #(
  parameter int NUM_CHAN   = qdfsl_pkg::NUM_CHAN,
  parameter int DIAG_W     = qdfsl_pkg::DIAG_W,
  parameter int FIFO_DEPTH = qdfsl_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // Device control pins
  input  wire logic                flag_clear_n,
  input  wire logic                supply_ok,
  input  wire logic [NUM_CHAN-1:0] chan_in,
  output logic      [NUM_CHAN-1:0] drive_on,
  // Fault detectors
  input  wire logic [NUM_CHAN-1:0] overtemp_detect,
  input  wire logic [NUM_CHAN-1:0] openload_detect,
  // Interrupt, open drain
  output logic                     int_out,
  output logic                     int_oe,
  // Serial link
  input  wire logic                cs_n,
  input  wire logic                sck,
  input  wire logic                si,
  output logic                     so_out,
  output logic                     so_oe,
  // Received bytes
  output logic                     rx_valid,
  output logic      [DIAG_W-1:0]   rx_data,
  input  wire logic                rx_ready,
  output logic                     rx_overrun
);
  logic [NUM_CHAN-1:0]                    overtemp_flag;
  logic [NUM_CHAN-1:0]                    openload_flag;
  logic [NUM_CHAN-1:0]                    gate_latch;
  logic [NUM_CHAN-1:0]                    chan_in_q;
  logic [DIAG_W-1:0]                      fault_status_shift;
  logic [DIAG_W-1:0]                      diag_word;
  logic [qdfsl_pkg::BIT_CNT_W-1:0]        bit_cnt;
  logic [qdfsl_pkg::INT_CNT_W-1:0]        int_cnt;
  logic                                   any_fault;
  logic                                   any_fault_q;
  logic                                   cs_q;
  logic                                   sck_q;
  logic                                   cs_fall;
  logic                                   sck_rise;
  logic                                   sck_fall;
  logic                                   byte_done;
  logic                                   fifo_in_ready;
  logic [DIAG_W-1:0]                      next_byte;
  qdfsl_pkg::qdfsl_link_t                 link_state;

  function automatic logic [DIAG_W-1:0] pack_diag(input logic [NUM_CHAN-1:0] ot,
                                                  input logic [NUM_CHAN-1:0] ol);
    logic [DIAG_W-1:0] w;
    w = qdfsl_pkg::DIAG_RESET;
    w[qdfsl_pkg::OT_LSB +: NUM_CHAN] = ot;
    w[qdfsl_pkg::OL_LSB +: NUM_CHAN] = ol;
    return w;
  endfunction

  // [RULE2] Fixed bit layout
  assign diag_word = pack_diag(overtemp_flag, openload_flag);
  assign any_fault = |diag_word;
  // [RULE19] Edges ignored when deselected
  assign cs_fall   = !cs_n && cs_q;
  assign sck_rise  = !cs_n && sck && !sck_q;
  assign sck_fall  = !cs_n && !sck && sck_q;
  assign next_byte = {fault_status_shift[DIAG_W-2:0], si};
  assign byte_done = sck_fall && (bit_cnt == qdfsl_pkg::BIT_LAST);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_q        <= 1'b1;
      sck_q       <= 1'b0;
      chan_in_q   <= '0;
      any_fault_q <= 1'b0;
    end else begin
      cs_q        <= cs_n;
      sck_q       <= sck;
      chan_in_q   <= chan_in;
      any_fault_q <= any_fault;
    end
  end

  // Per-channel flags and gate latch
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    // [RULE1] Flags per channel
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        overtemp_flag[c] <= 1'b0;
        openload_flag[c] <= 1'b0;
      // [RULE11] Clear flags only
      end else if (!flag_clear_n) begin
        overtemp_flag[c] <= 1'b0;
        openload_flag[c] <= 1'b0;
      end else begin
        // [RULE16] Overtemp sets flag
        if (overtemp_detect[c]) begin
          overtemp_flag[c] <= 1'b1;
        end
        // [RULE17] Set while off wins over clear
        if (openload_detect[c] && !chan_in[c]) begin
          openload_flag[c] <= 1'b1;
        end else if (chan_in_q[c] && !chan_in[c]) begin
          openload_flag[c] <= 1'b0;
        end
      end
    end

    // [RULE16] Latch off, re-armed on input rise
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        gate_latch[c] <= 1'b1;
      end else if (overtemp_detect[c]) begin
        gate_latch[c] <= 1'b0;
      end else if (chan_in[c] && !chan_in_q[c]) begin
        gate_latch[c] <= 1'b1;
      end
    end

    // [RULE12] [RULE14] Drivers forced off
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        drive_on[c] <= 1'b0;
      end else begin
        drive_on[c] <= chan_in[c] && gate_latch[c] && !overtemp_detect[c] && flag_clear_n && supply_ok;
      end
    end
  end

  // [RULE18] One-shot with lockout
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_cnt <= '0;
      int_oe  <= 1'b0;
    end else if (int_cnt != '0) begin
      int_cnt <= int_cnt - 1'b1;
      int_oe  <= (int_cnt != qdfsl_pkg::INT_CNT_W'(1));
    end else if (any_fault && !any_fault_q) begin
      int_cnt <= qdfsl_pkg::INT_CNT_W'(qdfsl_pkg::INT_CYCLES);
      int_oe  <= 1'b1;
    end
  end

  // Open drain only ever pulls low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_out <= 1'b0;
    end else begin
      int_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      link_state <= qdfsl_pkg::QDFSL_IDLE;
    end else begin
      unique case (link_state)
        qdfsl_pkg::QDFSL_IDLE: begin
          if (cs_fall) begin
            link_state <= qdfsl_pkg::QDFSL_SELECTED;
          end
        end
        qdfsl_pkg::QDFSL_SELECTED: begin
          if (cs_n) begin
            link_state <= qdfsl_pkg::QDFSL_IDLE;
          end
        end
      endcase
    end
  end

  // Device reset pin leaves it alone so a chain keeps its contents
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fault_status_shift <= qdfsl_pkg::DIAG_RESET;
    // [RULE5] Parallel load on select
    end else if (cs_fall) begin
      fault_status_shift <= diag_word;
    // [RULE4] [RULE20] Shift in on fall
    end else if (sck_fall) begin
      fault_status_shift <= next_byte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || cs_fall) begin
      bit_cnt <= qdfsl_pkg::BIT_FIRST;
    end else if (sck_fall) begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    // [RULE19] High-Z while deselected
    end else if (cs_n) begin
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    // [RULE6] Drive low until first rise
    end else if (cs_fall) begin
      so_out <= 1'b0;
      so_oe  <= 1'b1;
    // [RULE3] [RULE7] MSB out on rise
    end else if (sck_rise) begin
      so_out <= fault_status_shift[DIAG_W-1];
    end
  end

  // Link cannot stall, so a full FIFO drops the byte and flags it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_overrun <= 1'b0;
    end else if (byte_done && !fifo_in_ready) begin
      rx_overrun <= 1'b1;
    end
  end

  qdfsl_fifo #(
    .WIDTH (DIAG_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (byte_done),
    .in_data   (next_byte),
    .in_ready  (fifo_in_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );

  // [RULE2] Load matches layout
  a_load_layout: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cs_fall |=> fault_status_shift == {$past(openload_flag), $past(overtemp_flag)})
    else $error("shift register not loaded with flag layout"); // [RULE5]
  a_so_low_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cs_fall |=> so_oe && !so_out)
    else $error("serial output not driven low at select"); // [RULE6]
  a_so_msb_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sck_rise && !cs_fall |=> so_out == $past(fault_status_shift[DIAG_W-1]))
    else $error("serial output not MSB on rise"); // [RULE3]
  a_shift_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sck_fall && !cs_fall |=> fault_status_shift == {$past(fault_status_shift[DIAG_W-2:0]), $past(si)})
    else $error("input not shifted on fall"); // [RULE4]
  a_idle_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cs_n && $past(cs_n) |=> !so_oe && $stable(fault_status_shift))
    else $error("link active while deselected"); // [RULE19]
  a_clear_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !flag_clear_n |=> diag_word == '0 && drive_on == '0)
    else $error("reset input did not clear flags and drivers"); // [RULE11]
  a_supply_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !supply_ok |=> drive_on == '0)
    else $error("drivers on below supply threshold"); // [RULE14]
  a_ot_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    overtemp_detect[0] && flag_clear_n |=> overtemp_flag[0] && !gate_latch[0])
    else $error("overtemp did not set flag and drop latch"); // [RULE16]
  a_ol_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flag_clear_n && chan_in_q[0] && !chan_in[0] && !openload_detect[0] |=> !openload_flag[0])
    else $error("open-load flag not cleared on input fall"); // [RULE17]
  a_int_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(int_oe) |=> int_oe [*8])
    else $error("interrupt pulse too short"); // [RULE18]
  a_int_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(int_oe) |-> ##[149:151] !int_oe)
    else $error("interrupt pulse width wrong"); // [RULE18]

  c_full_byte: cover property (@(posedge clk_sys) disable iff (!rst_n) byte_done);
  c_interrupt: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(int_oe));
  c_overrun:   cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(rx_overrun));
endmodule
